//--- logic/wcr_clk_div.sv
// System clock divider and four-phase instruction timing
`timescale 1ns/10ps
module wcr_clk_div
	import wcr_pkg::*;
(
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       run,
	input  wire logic [2:0] clock_divide_select,
	input  wire logic       osc_16mhz,
	input  wire logic       lf_tick,
	output logic            sys_tick,
	output logic            phase_one_clock,
	output logic            phase_four_clock
);

	// ----------------------------------------------------------------
	// Divide ratio
	// ----------------------------------------------------------------
	logic [7:0] div_cnt_reg;
	logic [1:0] phase_reg;
	logic [3:0] div_shift;
	logic [7:0] div_last;
	logic       lf_mode;
	logic       tick_next;

	// Code 111 is /1; an 8 MHz source needs one extra halving
	assign div_shift = {1'b0, 3'h7 - clock_divide_select} + {3'h0, ~osc_16mhz};
	assign div_last  = wcr_pow2_mask(div_shift);
	assign lf_mode   = (clock_divide_select == DIV_LF_CODE);
	// The >= keeps a ratio change mid-count from skipping a whole wrap
	assign tick_next = run & (lf_mode ? lf_tick : (div_cnt_reg >= div_last));

	// ----------------------------------------------------------------
	// Counter and phases
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			div_cnt_reg <= 8'h00;
		else if (!run || tick_next)
			div_cnt_reg <= 8'h00;
		else
			div_cnt_reg <= div_cnt_reg + 8'h01;
	end

	// Phase parks at four so the first tick after start is phase one
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			phase_reg        <= 2'h3;
			sys_tick         <= 1'b0;
			phase_one_clock  <= 1'b0;
			phase_four_clock <= 1'b0;
		end
		else
		begin
			sys_tick         <= tick_next;
			phase_one_clock  <= tick_next & (phase_reg == 2'h3);
			phase_four_clock <= tick_next & (phase_reg == 2'h2);
			if (!run)
				phase_reg <= 2'h3;
			else if (tick_next)
				phase_reg <= phase_reg + 2'h1;
		end
	end

endmodule

//--- logic/wcr_pkg.sv
// Shared constants, register map and types for the watchdog, clock and reset block
package wcr_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int unsigned PCLK_HZ         = 25_000_000;
	localparam int unsigned WDT_OSC_HZ      = 32_000;
	localparam int unsigned WDT_BASE_MS     = 18;
	localparam int unsigned STAB_MS         = 18;
	localparam int unsigned WDT_DEFAULT_MS  = 144;
	localparam int unsigned WDT_BASE_TICKS  = (WDT_BASE_MS * WDT_OSC_HZ + 999) / 1000;
	localparam int unsigned STAB_TICKS      = (STAB_MS * WDT_OSC_HZ + 999) / 1000;
	localparam int unsigned CNT_W           = 16;

	// ----------------------------------------------------------------
	// Register indices (byte address is four times the index)
	// ----------------------------------------------------------------
	localparam int unsigned ADDR_W          = 12;
	localparam logic [7:0]  IDX_STATUS      = 8'h03;
	localparam logic [7:0]  IDX_OPTION      = 8'h81;
	localparam logic [7:0]  IDX_OSC_CTRL    = 8'h88;
	localparam logic [7:0]  IDX_WDT_CTRL    = 8'h89;
	localparam logic [7:0]  IDX_COMMAND     = 8'h8A;

	// ----------------------------------------------------------------
	// Reset values, masks and field positions
	// ----------------------------------------------------------------
	localparam logic [7:0]  OPTION_RESET    = 8'h7B;
	localparam logic [7:0]  OPTION_MASK     = 8'h7F;
	localparam logic [7:0]  OSC_CTRL_RESET  = 8'h60;
	localparam logic [7:0]  OSC_CTRL_MASK   = 8'h70;
	localparam logic [7:0]  WDT_CTRL_RESET  = 8'h00;
	localparam logic [7:0]  WDT_CTRL_MASK   = 8'h01;
	localparam int unsigned OSC_DIV_LSB     = 4;
	localparam int unsigned WDT_EN_BIT      = 0;
	localparam int unsigned CMD_CLEAR_BIT   = 0;
	localparam int unsigned CMD_STOP_BIT    = 1;
	localparam int unsigned ST_TO_BIT       = 4;
	localparam int unsigned ST_PD_BIT       = 3;
	localparam logic [2:0]  DIV_LF_CODE     = 3'h0;
	localparam logic [10:0] FETCH_RESET     = 11'h000;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0]
	{
		WCR_POWER_WAIT = 2'b00,
		WCR_INIT       = 2'b01,
		WCR_OSC_START  = 2'b10,
		WCR_RUN        = 2'b11
	} wcr_seq_t;

	typedef struct packed
	{
		logic overflow_flag;
		logic sleep_flag;
	} wcr_flags_t;

	typedef struct packed
	{
		logic [3:0] other;
		logic       prescaler_owner_select;
		logic [2:0] prescale_ratio;
	} wcr_option_t;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [7:0] wcr_pow2_mask(input logic [3:0] n);
		logic [8:0] one_hot;
		one_hot = 9'h001 << n;
		return 8'(one_hot - 9'h001);
	endfunction

endpackage

//--- logic/wcr_watchdog_ctrl.sv
// Watchdog, shared scaler, reset sequencer and APB registers
`timescale 1ns/10ps
module wcr_watchdog_ctrl
	import wcr_pkg::*;
#(
	parameter int unsigned BASE_TICKS = WDT_BASE_TICKS,
	parameter int unsigned HOLD_TICKS = STAB_TICKS
)
(
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic              wdt_osc_pin,
	input  wire logic              low_voltage_reset,
	input  wire logic              cfg_watchdog_force,
	input  wire logic              cfg_osc_16mhz,
	input  wire logic              timer_tick,
	input  wire logic              timer_written,
	output logic                   timer_scaled_tick,
	output logic                   core_reset_n,
	output logic                   watchdog_reset_event,
	output logic      [10:0]       fetch_addr,
	output logic                   sys_tick,
	output logic                   phase_one_clock,
	output logic                   phase_four_clock
);

	localparam logic [CNT_W-1:0] BASE_LAST = CNT_W'(BASE_TICKS - 1);
	localparam logic [CNT_W-1:0] HOLD_LAST = CNT_W'(HOLD_TICKS - 1);

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic [2:0] osc_sync_reg;
	logic [2:0] lvr_sync_reg;
	logic       osc_level_reg;
	logic       lvr_level_reg;
	logic       osc_agree;
	logic       lvr_agree;
	logic       osc_tick;

	assign osc_agree = (osc_sync_reg[1] == osc_sync_reg[2]);
	assign lvr_agree = (lvr_sync_reg[1] == lvr_sync_reg[2]);
	// Rising edge of the filtered oscillator level
	assign osc_tick  = osc_agree & osc_sync_reg[2] & ~osc_level_reg;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			osc_sync_reg  <= 3'h0;
			lvr_sync_reg  <= 3'h0;
			osc_level_reg <= 1'b0;
			lvr_level_reg <= 1'b0;
		end
		else
		begin
			osc_sync_reg <= {osc_sync_reg[1:0], wdt_osc_pin};
			lvr_sync_reg <= {lvr_sync_reg[1:0], low_voltage_reset};
			if (osc_agree)
				osc_level_reg <= osc_sync_reg[2];
			if (lvr_agree)
				lvr_level_reg <= lvr_sync_reg[2];
		end
	end

	// ----------------------------------------------------------------
	// Registers and APB decode
	// ----------------------------------------------------------------
	wcr_option_t option_reg;
	logic [7:0]  osc_ctrl_reg;
	logic [7:0]  wdt_ctrl_reg;
	wcr_flags_t  flags_reg;
	wcr_seq_t    seq_reg;
	wcr_seq_t    seq_next;

	logic [7:0]  reg_index;
	logic        addr_ok;
	logic        hit_status;
	logic        hit_option;
	logic        hit_osc;
	logic        hit_wdt;
	logic        hit_cmd;
	logic        mapped;
	logic        setup_phase;
	logic        write_fire;
	logic [7:0]  rd_byte;
	logic [7:0]  status_byte;
	logic        regs_init;
	logic        clear_op;
	logic        stop_op;
	logic        clear_any;

	assign reg_index   = paddr[9:2];
	assign addr_ok     = (paddr[1:0] == 2'h0) & (paddr[ADDR_W-1:10] == 2'h0);
	assign hit_status  = addr_ok & (reg_index == IDX_STATUS);
	assign hit_option  = addr_ok & (reg_index == IDX_OPTION);
	assign hit_osc     = addr_ok & (reg_index == IDX_OSC_CTRL);
	assign hit_wdt     = addr_ok & (reg_index == IDX_WDT_CTRL);
	assign hit_cmd     = addr_ok & (reg_index == IDX_COMMAND);
	assign mapped      = hit_status | hit_option | hit_osc | hit_wdt | hit_cmd;
	assign setup_phase = psel & ~penable;
	assign write_fire  = psel & penable & pwrite & pready & ~pslverr;

	assign status_byte = (8'(flags_reg.overflow_flag) << ST_TO_BIT)
		| (8'(flags_reg.sleep_flag) << ST_PD_BIT);
	assign rd_byte     = hit_status ? status_byte :
		hit_option ? (option_reg & OPTION_MASK) :
		hit_osc ? (osc_ctrl_reg & OSC_CTRL_MASK) :
		hit_wdt ? (wdt_ctrl_reg & WDT_CTRL_MASK) : 8'h00;

	// Register defaults return while the sequencer is in the power-wait or init state
	assign regs_init   = (seq_reg == WCR_INIT) | (seq_reg == WCR_POWER_WAIT);
	assign clear_op    = write_fire & hit_cmd & pwdata[CMD_CLEAR_BIT];
	assign stop_op     = write_fire & hit_cmd & pwdata[CMD_STOP_BIT];
	assign clear_any   = clear_op | stop_op;

	// Zero-wait slave: data and error are prepared in the setup cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata  <= 32'h0000_0000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
		else
		begin
			pready <= 1'b1;
			if (setup_phase)
			begin
				prdata  <= {24'h00_0000, pwrite ? 8'h00 : rd_byte};
				pslverr <= ~mapped;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			option_reg   <= OPTION_RESET;
			osc_ctrl_reg <= OSC_CTRL_RESET;
			wdt_ctrl_reg <= WDT_CTRL_RESET;
		end
		else if (regs_init)
		begin
			option_reg   <= OPTION_RESET;
			osc_ctrl_reg <= OSC_CTRL_RESET;
			wdt_ctrl_reg <= WDT_CTRL_RESET;
		end
		else if (write_fire)
		begin
			if (hit_option)
				option_reg <= pwdata[7:0] & OPTION_MASK;
			if (hit_osc)
				osc_ctrl_reg <= pwdata[7:0] & OSC_CTRL_MASK;
			if (hit_wdt)
				wdt_ctrl_reg <= pwdata[7:0] & WDT_CTRL_MASK;
		end
	end

	// ----------------------------------------------------------------
	// Watchdog counter and shared scaler
	// ----------------------------------------------------------------
	logic [CNT_W-1:0] base_cnt_reg;
	logic [7:0]       scaler_reg;
	logic             owner_wdt;
	logic             wdt_active;
	logic             base_ovf;
	logic [7:0]       wdt_last;
	logic [7:0]       tmr_last;
	logic             scaler_wrap;
	logic             wdt_fire;
	logic             tmr_step;

	assign owner_wdt   = option_reg.prescaler_owner_select;
	// Force bit overrides the software enable; counting only while running
	assign wdt_active  = (cfg_watchdog_force | wdt_ctrl_reg[WDT_EN_BIT])
		& (seq_reg == WCR_RUN);
	assign base_ovf    = wdt_active & osc_tick & (base_cnt_reg == BASE_LAST);
	assign wdt_last    = wcr_pow2_mask({1'b0, option_reg.prescale_ratio});
	assign tmr_last    = wcr_pow2_mask({1'b0, option_reg.prescale_ratio} + 4'h1);
	assign scaler_wrap = scaler_reg == (owner_wdt ? wdt_last : tmr_last);
	// Without the scaler the watchdog runs 1:1; a clear in the same cycle wins
	assign wdt_fire    = base_ovf & (~owner_wdt | scaler_wrap) & ~clear_any;
	assign tmr_step    = ~owner_wdt & timer_tick & (seq_reg == WCR_RUN);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			base_cnt_reg <= '0;
		else if (regs_init || clear_any)
			base_cnt_reg <= '0;
		else if (wdt_active && osc_tick)
			base_cnt_reg <= (base_cnt_reg == BASE_LAST) ? '0 : base_cnt_reg + 1'b1;
	end

	// A single counter: whichever side owns it is the only one that steps it
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			scaler_reg <= 8'h00;
		else if (regs_init)
			scaler_reg <= 8'h00;
		else if (owner_wdt && clear_any)
			scaler_reg <= 8'h00;
		else if (!owner_wdt && timer_written)
			scaler_reg <= 8'h00;
		else if ((owner_wdt && base_ovf) || tmr_step)
			scaler_reg <= scaler_wrap ? 8'h00 : scaler_reg + 8'h01;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			timer_scaled_tick    <= 1'b0;
			watchdog_reset_event <= 1'b0;
		end
		else
		begin
			timer_scaled_tick    <= owner_wdt ? timer_tick : (tmr_step & scaler_wrap);
			watchdog_reset_event <= wdt_fire;
		end
	end

	// ----------------------------------------------------------------
	// Status flags
	// ----------------------------------------------------------------
	// Flags survive the init state so software can read the reset cause
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			flags_reg <= '{overflow_flag: 1'b1, sleep_flag: 1'b1};
		else if (lvr_level_reg)
			flags_reg <= '{overflow_flag: 1'b1, sleep_flag: 1'b1};
		else if (wdt_fire)
			flags_reg.overflow_flag <= 1'b0;
		else if (stop_op)
			flags_reg <= '{overflow_flag: 1'b1, sleep_flag: 1'b0};
		else if (clear_op)
			flags_reg <= '{overflow_flag: 1'b1, sleep_flag: 1'b1};
	end

	// ----------------------------------------------------------------
	// Reset sequencer
	// ----------------------------------------------------------------
	logic [CNT_W-1:0] hold_cnt_reg;
	logic             hold_done;

	assign hold_done = osc_tick & (hold_cnt_reg == HOLD_LAST);

	always_comb
	begin
		seq_next = seq_reg;
		unique case (seq_reg)
			WCR_POWER_WAIT:
				if (!lvr_level_reg)
					seq_next = WCR_INIT;
			WCR_INIT:
				seq_next = WCR_OSC_START;
			WCR_OSC_START:
				if (hold_done)
					seq_next = WCR_RUN;
			WCR_RUN:
				seq_next = WCR_RUN;
		endcase
		if (lvr_level_reg)
			seq_next = WCR_POWER_WAIT;
		else if (wdt_fire)
			seq_next = WCR_INIT;
	end

	// Oscillator timing means the hold is only as exact as the RC source
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			hold_cnt_reg <= '0;
		else if (seq_reg != WCR_OSC_START)
			hold_cnt_reg <= '0;
		else if (osc_tick)
			hold_cnt_reg <= hold_cnt_reg + 1'b1;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			seq_reg      <= WCR_POWER_WAIT;
			core_reset_n <= 1'b0;
		end
		else
		begin
			seq_reg      <= seq_next;
			core_reset_n <= (seq_next == WCR_RUN);
		end
	end

	// ----------------------------------------------------------------
	// Clock divider and fetch address
	// ----------------------------------------------------------------
	wcr_clk_div u_clk_div
	(
		.pclk                (pclk),
		.presetn             (presetn),
		.run                 (seq_reg == WCR_RUN),
		.clock_divide_select (osc_ctrl_reg[OSC_DIV_LSB +: 3]),
		.osc_16mhz           (cfg_osc_16mhz),
		.lf_tick             (osc_tick),
		.sys_tick            (sys_tick),
		.phase_one_clock     (phase_one_clock),
		.phase_four_clock    (phase_four_clock)
	);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			fetch_addr <= FETCH_RESET;
		else if (seq_next != WCR_RUN)
			fetch_addr <= FETCH_RESET;
		else if (phase_one_clock)
			fetch_addr <= fetch_addr + 11'h001;
	end

endmodule

//--- test/wcr_watchdog_ctrl_bench.sv
// Self-checking bench for the watchdog, clock and reset block
`timescale 1ns/10ps
module wcr_watchdog_ctrl_bench;
	import wcr_pkg::*;
	// Small counts keep overflow and hold times to tens of cycles
	localparam int BT = 4;
	localparam int HT = 4;
	logic              pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
	logic [ADDR_W-1:0] paddr;
	logic [31:0]       pwdata, prdata, rd, rng;
	logic              wdt_osc_pin, low_voltage_reset, cfg_watchdog_force, cfg_osc_16mhz;
	logic              timer_tick, timer_written, timer_scaled_tick, core_reset_n;
	logic              watchdog_reset_event, sys_tick, phase_one_clock, phase_four_clock;
	logic [10:0]       fetch_addr;
	logic [2:0]        osc_div;
	int                errors, cmp_count, evt_cnt, st_cnt, p1_cnt, ts_cnt, n, n1;

	wcr_watchdog_ctrl #(.BASE_TICKS(BT), .HOLD_TICKS(HT)) dut (.pclk, .presetn, .psel,
		.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .wdt_osc_pin,
		.low_voltage_reset, .cfg_watchdog_force, .cfg_osc_16mhz, .timer_tick,
		.timer_written, .timer_scaled_tick, .core_reset_n, .watchdog_reset_event,
		.fetch_addr, .sys_tick, .phase_one_clock, .phase_four_clock);
	// --------
	// Clocks and event counters
	// --------
	initial
	begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end
	// Free-running RC stand-in: 8 pclk period, each level 4 cycles
	assign wdt_osc_pin = osc_div[2];
	always @(posedge pclk)
	begin
		osc_div <= osc_div + 3'h1;
		evt_cnt <= evt_cnt + int'(watchdog_reset_event === 1'b1);
		st_cnt <= st_cnt + int'(sys_tick === 1'b1);
		p1_cnt <= p1_cnt + int'(phase_one_clock === 1'b1);
		ts_cnt <= ts_cnt + int'(timer_scaled_tick === 1'b1);
	end
	// --------
	// Helpers
	// --------
	function automatic logic [31:0] xs(input logic [31:0] v);
		v ^= v << 13;
		v ^= v >> 17;
		v ^= v << 5;
		return v;
	endfunction
	task automatic print_verdict();
		$display("Comparisons %0d, mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic to_out();
		errors++;
		print_verdict();
	endtask
	task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
		cmp_count++;
		if (got !== ex)
		begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
		end
	endtask
	task automatic near(input string nm, input int ex, input int got, input int tol);
		cmp_count++;
		if (got < ex - tol || got > ex + tol)
		begin
			errors++;
			$display("CHECK FAILED %s expected %0d seen %0d", nm, ex, got);
		end
	endtask
	task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] d);
		int k;
		k = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= {2'b00, idx, 2'b00};
		pwdata <= {24'h00_0000, d};
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && k < 20)
		begin
			k++;
			@(posedge pclk);
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (k == 20)
			to_out();
	endtask
	task automatic rdc(input logic [7:0] idx, input logic [7:0] ex, input string nm);
		apb(1'b0, idx, 8'h00);
		chk(nm, {24'h00_0000, ex}, rd);
	endtask
	task automatic wait_run(output int k);
		k = 0;
		while (core_reset_n !== 1'b1 && k < 3000)
		begin
			k++;
			@(negedge pclk);
		end
		if (k == 3000)
			to_out();
		@(posedge pclk);
	endtask
	task automatic wait_evt(input int lim, output int k);
		int e0;
		e0 = evt_cnt;
		k = 0;
		while (evt_cnt == e0 && k < lim)
		begin
			k++;
			@(posedge pclk);
		end
	endtask
	task automatic ovf(input logic [7:0] opt, input int ex, input logic [7:0] st);
		int k;
		apb(1'b1, IDX_OPTION, opt);
		apb(1'b1, IDX_WDT_CTRL, 8'h01);
		wait_evt(ex + 64, k);
		near("overflow interval", ex, k, 12);
		wait_run(k);
		near("stabilise hold", HT * 8, k, 8);
		rdc(IDX_STATUS, st, "status after overflow");
		rdc(IDX_WDT_CTRL, 8'h00, "wdt_ctrl after overflow");
		rdc(IDX_OPTION, 8'h7B, "option after overflow");
	endtask
	task automatic meas(input int ex);
		int s0, q0;
		repeat (8)
			@(posedge pclk);
		s0 = st_cnt;
		q0 = p1_cnt;
		repeat (256)
			@(posedge pclk);
		near("sys ticks", ex, st_cnt - s0, 1);
		near("phase one ticks", ex / 4, p1_cnt - q0, 1);
	endtask
	task automatic ticks(input int cnt);
		repeat (cnt)
		begin
			timer_tick <= 1'b1;
			@(posedge pclk);
			timer_tick <= 1'b0;
			rng = xs(rng);
			repeat (1 + rng[1:0])
				@(posedge pclk);
		end
		repeat (3)
			@(posedge pclk);
	endtask
	task automatic tw_pulse();
		timer_written <= 1'b1;
		@(posedge pclk);
		timer_written <= 1'b0;
	endtask
	// --------
	// Scenarios
	// --------
	initial
	begin
		{osc_div, presetn, psel, penable, pwrite, low_voltage_reset} = '0;
		{cfg_watchdog_force, timer_tick, timer_written, paddr, pwdata} = '0;
		cfg_osc_16mhz = 1'b1;
		rng = 32'h0000_0038;
		repeat (3)
			@(posedge pclk);
		presetn <= 1'b1;
		wait_run(n);
		rdc(IDX_OPTION, 8'h7B, "option reset");
		rdc(IDX_OSC_CTRL, 8'h60, "osc_ctrl reset");
		rdc(IDX_WDT_CTRL, 8'h00, "wdt_ctrl reset");
		rdc(IDX_STATUS, 8'h18, "status reset");
		apb(1'b0, 8'h40, 8'h00);
		chk("unmapped error", 32'h0000_0001, 32'(er));
		chk("unmapped data", 32'h0000_0000, rd);
		repeat (6)
		begin
			rng = xs(rng);
			apb(1'b1, IDX_OPTION, rng[7:0]);
			rdc(IDX_OPTION, rng[7:0] & 8'h7F, "option rw");
			apb(1'b1, IDX_WDT_CTRL, rng[15:8] & 8'hFE);
			rdc(IDX_WDT_CTRL, 8'h00, "wdt_ctrl rw");
			apb(1'b1, IDX_STATUS, rng[23:16]);
			rdc(IDX_STATUS, 8'h18, "status read only");
		end
		for (int c = 7; c >= 0; c--)
		begin
			apb(1'b1, IDX_OSC_CTRL, {1'b0, 3'(c), 4'h0});
			meas(c == 0 ? 32 : 256 >> (7 - c));
		end
		cfg_osc_16mhz <= 1'b0;
		apb(1'b1, IDX_OSC_CTRL, 8'h70);
		meas(128);
		cfg_osc_16mhz <= 1'b1;
		apb(1'b1, IDX_OSC_CTRL, 8'h60);
		apb(1'b1, IDX_COMMAND, 8'h02);
		rdc(IDX_STATUS, 8'h10, "status stop");
		apb(1'b1, IDX_COMMAND, 8'h01);
		rdc(IDX_STATUS, 8'h18, "status clear");
		ovf(8'h70, BT * 8, 8'h08);
		for (int r = 0; r < 3; r++)
			ovf(8'h78 | 8'(r), (BT * 8) << r, 8'h08);
		ovf(8'h7B, BT * 64, 8'h08);
		// Clears every 83 cycles; a scaler left uncleared would fire by the second
		apb(1'b1, IDX_OPTION, 8'h7A);
		apb(1'b1, IDX_WDT_CTRL, 8'h01);
		rdc(IDX_WDT_CTRL, 8'h01, "wdt_ctrl on");
		n1 = evt_cnt;
		for (int i = 0; i < 6; i++)
		begin
			apb(1'b1, IDX_COMMAND, i[0] ? 8'h02 : 8'h01);
			repeat (80)
				@(posedge pclk);
		end
		chk("no overflow while cleared", n1, evt_cnt);
		apb(1'b1, IDX_COMMAND, 8'h01);
		wait_evt(400, n);
		near("interval after clear", BT * 32, n, 12);
		wait_run(n);
		apb(1'b1, IDX_OPTION, 8'h70);
		n1 = evt_cnt;
		repeat (100)
			@(posedge pclk);
		chk("disabled watchdog", n1, evt_cnt);
		cfg_watchdog_force <= 1'b1;
		wait_evt(200, n);
		near("forced interval", BT * 8, n, 12);
		cfg_watchdog_force <= 1'b0;
		wait_run(n);
		apb(1'b1, IDX_OSC_CTRL, 8'h30);
		low_voltage_reset <= 1'b1;
		repeat (12)
			@(posedge pclk);
		@(negedge pclk);
		chk("low voltage core reset", 32'h0000_0000, 32'(core_reset_n));
		@(posedge pclk);
		low_voltage_reset <= 1'b0;
		wait_run(n);
		rdc(IDX_OSC_CTRL, 8'h60, "osc_ctrl after low voltage");
		rdc(IDX_STATUS, 8'h18, "status after low voltage");
		apb(1'b1, IDX_OPTION, 8'h70);
		tw_pulse();
		n1 = ts_cnt;
		ticks(16);
		chk("timer ratio 1:2", n1 + 8, ts_cnt);
		ticks(1);
		tw_pulse();
		n1 = ts_cnt;
		ticks(3);
		chk("timer write clears scaler", n1 + 1, ts_cnt);
		apb(1'b1, IDX_OPTION, 8'h78);
		n1 = ts_cnt;
		ticks(4);
		chk("timer 1:1 when scaler on watchdog", n1 + 4, ts_cnt);
		print_verdict();
	end
endmodule

//--- test/wcr_watchdog_ctrl_chk.sv
// Port checker for the watchdog, clock and reset block
`timescale 1ns/10ps
module wcr_watchdog_ctrl_chk
	import wcr_pkg::*;
#(
	parameter int unsigned BASE_TICKS = WDT_BASE_TICKS,
	parameter int unsigned HOLD_TICKS = STAB_TICKS
)
(
	input wire logic              pclk,
	input wire logic              presetn,
	input wire logic              psel,
	input wire logic              penable,
	input wire logic              pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0]       pwdata,
	input wire logic [31:0]       prdata,
	input wire logic              pready,
	input wire logic              pslverr,
	input wire logic              wdt_osc_pin,
	input wire logic              low_voltage_reset,
	input wire logic              cfg_watchdog_force,
	input wire logic              cfg_osc_16mhz,
	input wire logic              timer_tick,
	input wire logic              timer_written,
	input wire logic              timer_scaled_tick,
	input wire logic              core_reset_n,
	input wire logic              watchdog_reset_event,
	input wire logic [10:0]       fetch_addr,
	input wire logic              sys_tick,
	input wire logic              phase_one_clock,
	input wire logic              phase_four_clock
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// --------
	// Reset sequencing
	// --------
	// Hold after an overflow is far longer than 8 cycles; 8 keeps the unroll cheap
	sequence s_held;
		!core_reset_n [*8];
	endsequence
	property p_evt_hold;
		watchdog_reset_event |-> !core_reset_n ##1 s_held;
	endproperty
	a_evt_hold: assert property (p_evt_hold)
		else $error("core released too soon after overflow");
	property p_evt_pulse;
		watchdog_reset_event |=> !watchdog_reset_event;
	endproperty
	a_evt_pulse: assert property (p_evt_pulse)
		else $error("overflow event longer than one cycle");
	property p_lvr;
		low_voltage_reset [*8] |-> !core_reset_n;
	endproperty
	a_lvr: assert property (p_lvr)
		else $error("low voltage did not hold the core");
	property p_fetch_zero;
		!core_reset_n |-> fetch_addr == FETCH_RESET;
	endproperty
	a_fetch_zero: assert property (p_fetch_zero)
		else $error("fetch address not zero in reset");
	// --------
	// Phases and fetch
	// --------
	property p_phase_excl;
		phase_one_clock |-> !phase_four_clock;
	endproperty
	a_phase_excl: assert property (p_phase_excl)
		else $error("phase one and four overlap");
	property p_p1_gap;
		phase_one_clock |=> !phase_one_clock [*3];
	endproperty
	a_p1_gap: assert property (p_p1_gap)
		else $error("phase one closer than four ticks");
	property p_p4_gap;
		phase_four_clock |=> !phase_four_clock [*3];
	endproperty
	a_p4_gap: assert property (p_p4_gap)
		else $error("phase four closer than four ticks");
	property p_fetch_step;
		phase_one_clock && core_reset_n |=>
			!core_reset_n || fetch_addr == $past(fetch_addr) + 11'h001;
	endproperty
	a_fetch_step: assert property (p_fetch_step)
		else $error("fetch address did not advance on phase one");
	property p_fetch_hold;
		core_reset_n && !phase_one_clock |=> !core_reset_n || $stable(fetch_addr);
	endproperty
	a_fetch_hold: assert property (p_fetch_hold)
		else $error("fetch address moved outside phase one");
endmodule

bind wcr_watchdog_ctrl wcr_watchdog_ctrl_chk #(.BASE_TICKS(BASE_TICKS), .HOLD_TICKS(HOLD_TICKS))
	u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
	.pslverr, .wdt_osc_pin, .low_voltage_reset, .cfg_watchdog_force, .cfg_osc_16mhz,
	.timer_tick, .timer_written, .timer_scaled_tick, .core_reset_n, .watchdog_reset_event,
	.fetch_addr, .sys_tick, .phase_one_clock, .phase_four_clock);
